// File: fdfe_consts.vh
// fdfe_consts.vh: constants of the fetch and decode front end
// assumes inclusion by each design file that uses its constants, by bare name
`ifndef FDFE_CONSTS_VH
`define FDFE_CONSTS_VH

// fetch and decode widths
`define FDFE_FETCH_BYTES   16
`define FDFE_DEC_WIDTH     4
`define FDFE_MAX_DEC_UOPS  4
`define FDFE_UOP_W         16
`define FDFE_INS_W         24
`define FDFE_IQ_DEPTH      16
`define FDFE_IDQ_DEPTH     16
`define FDFE_IDQ_AW        4
`define FDFE_RSB_DEPTH     8
`define FDFE_ADDR_W        32
`define FDFE_LSD_MAX       8

// instruction word fields: [7:0] op class, [10:8] uop count-1,
// [14:11] condition code, [16:15] operand form, [23:17] tag
`define FDFE_F_CLS_HI      7
`define FDFE_F_CLS_LO      0
`define FDFE_F_CNT_HI      10
`define FDFE_F_CNT_LO      8
`define FDFE_F_CC_HI       14
`define FDFE_F_CC_LO       11
`define FDFE_F_FORM_HI     16
`define FDFE_F_FORM_LO     15

// op classes
`define FDFE_CLS_OTHER     8'h00
`define FDFE_CLS_CMP       8'h01
`define FDFE_CLS_TEST      8'h02
`define FDFE_CLS_JCC       8'h03
`define FDFE_CLS_CALL      8'h04
`define FDFE_CLS_RET       8'h05
`define FDFE_CLS_FUSED     8'h06
`define FDFE_CLS_UCODE     8'h07
`define FDFE_CLS_LOOPEND   8'h08

// condition codes (alias encodings share one code)
`define FDFE_CC_A          4'h7
`define FDFE_CC_AE         4'h3
`define FDFE_CC_E          4'h4
`define FDFE_CC_BE         4'h6
`define FDFE_CC_B          4'h2
`define FDFE_CC_NE         4'h5
`define FDFE_CC_L          4'hc
`define FDFE_CC_GE         4'hd
`define FDFE_CC_LE         4'he
`define FDFE_CC_G          4'hf

// operand forms (all four are fusable)
`define FDFE_FORM_RR       2'h0
`define FDFE_FORM_RI       2'h1
`define FDFE_FORM_RM       2'h2
`define FDFE_FORM_MR       2'h3

`endif

// File: fdfe_fifo.v
// fdfe_fifo.v: valid/ready FIFO with flip-flop storage
// assumes one clock, asynchronous active-high reset
`timescale 1ns/10ps
module fdfe_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             mclk,
    input  wire             sys_rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // honest full and empty
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers and occupancy
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end

    // storage, written without reset
    always @(posedge mclk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule // fdfe_fifo

// File: fdfe_fuse.v
// fdfe_fuse.v: decides whether a compare/test and a jump may fuse
// assumes instruction words laid out as in fdfe_consts.vh
`timescale 1ns/10ps
`include "fdfe_consts.vh"
module fdfe_fuse (
    // adjacent pair
    input  wire [`FDFE_INS_W-1:0] first,
    input  wire [`FDFE_INS_W-1:0] second,
    // verdict
    output reg                    fusable
);
    wire [7:0] cls0;
    wire [7:0] cls1;
    wire [3:0] cc;
    reg        cmp_cc_ok;

    assign cls0 = first[`FDFE_F_CLS_HI:`FDFE_F_CLS_LO];
    assign cls1 = second[`FDFE_F_CLS_HI:`FDFE_F_CLS_LO];
    assign cc   = second[`FDFE_F_CC_HI:`FDFE_F_CC_LO];

    // conditions a compare may fuse with
    always @* begin
        case (cc)
            `FDFE_CC_A, `FDFE_CC_AE, `FDFE_CC_E,
            `FDFE_CC_BE, `FDFE_CC_B, `FDFE_CC_NE:
                cmp_cc_ok = 1'b1;
            `FDFE_CC_L, `FDFE_CC_GE, `FDFE_CC_LE, `FDFE_CC_G:
                cmp_cc_ok = 1'b1;
            default:
                cmp_cc_ok = 1'b0;
        endcase
    end

    // every operand form qualifies; test takes any condition
    always @* begin
        fusable = 1'b0;
        if (cls1 == `FDFE_CLS_JCC) begin
            if (cls0 == `FDFE_CLS_TEST)
                fusable = 1'b1;
            else if (cls0 == `FDFE_CLS_CMP)
                fusable = cmp_cc_ok;
        end
    end
endmodule // fdfe_fuse

// File: fdfe_front_end.v
// fdfe_front_end.v: fetch, queue, fuse, decode and loop replay
// assumes an instruction cache supplying aligned 16-byte lines and a
// rename stage draining micro-ops with valid/ready
`timescale 1ns/10ps
`include "fdfe_consts.vh"

// Operation
// - fetch at most 16 aligned bytes per cycle
// - queue hands at most four instructions onward
// - three decoders take simple instructions only
// - fourth decoder also takes complex instructions
// - over four micro-ops come from microcode rom
// - at most four micro-ops written per cycle
// - decode alternates threads on successive cycles
// - loop detector replays short loops from queue
// - fuse compare/test with following conditional jump
// - fusion also active in 64-bit mode
// - test fuses with any condition
// - compare fuses with carry/zero conditions
// - compare fuses with signed conditions too
// - return stack buffer with renaming on returns
// - correct path proceeds right after misprediction
module fdfe_front_end (
    // clock and reset
    input  wire                     mclk,
    input  wire                     sys_rst,
    // thread and mode control
    input  wire                     smt_enable,
    input  wire                     long_mode,
    // instruction cache side
    input  wire                     fetch_valid,
    output wire                     fetch_ready,
    input  wire [127:0]             fetch_bytes,
    // length decoder results: four instruction words per line
    input  wire [4*`FDFE_INS_W-1:0] ld_ins,
    input  wire [3:0]               ld_mask,
    input  wire                     fetch_thread,
    // misprediction recovery
    input  wire                     mispredict,
    input  wire [`FDFE_ADDR_W-1:0]  call_ret_addr,
    // rename stage side
    output wire                     uop_valid,
    input  wire                     uop_ready,
    output wire [`FDFE_UOP_W-1:0]   uop_data,
    // status
    output reg                      lsd_active,
    output reg  [`FDFE_ADDR_W-1:0]  ret_predict,
    output reg                      flush_done
);
    localparam IQW = 4 + 4*`FDFE_INS_W;
    localparam ST_RUN   = 2'd0;
    localparam ST_UCODE = 2'd1;
    localparam ST_LOOP  = 2'd2;

    // instruction queue: a fetch line is a group of four words
    wire           iq_in_ready;
    wire           iq_out_valid;
    wire [IQW-1:0] iq_out;
    reg            iq_pop;
    wire           line_ok;
    wire [127:0]   fetch_unused;

    assign fetch_unused = fetch_bytes; // bytes go to length decoder
    assign line_ok      = fetch_valid & (ld_mask != 4'h0);
    assign fetch_ready  = iq_in_ready;

    fdfe_fifo #(
        .WIDTH (IQW),
        .DEPTH (`FDFE_IQ_DEPTH),
        .AW    (4)
    ) u_iq (
        .mclk      (mclk),
        .sys_rst   (sys_rst | mispredict),
        .in_valid  (line_ok),
        .in_ready  (iq_in_ready),
        .in_data   ({ld_mask, ld_ins}),
        .out_valid (iq_out_valid),
        .out_ready (iq_pop),
        .out_data  (iq_out)
    );

    // thread alternation: decode only on this thread's cycle
    reg  dec_thread;
    wire line_thread;
    wire my_turn;
    assign line_thread = fetch_thread;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            dec_thread <= 1'b0;
        else if (smt_enable)
            dec_thread <= ~dec_thread;
        else
            dec_thread <= 1'b0;
    end
    assign my_turn = ~smt_enable | (dec_thread == line_thread);

    // pair fusion checks on slots 0-1, 1-2, 2-3
    wire [`FDFE_INS_W-1:0] slot [0:3];
    wire [2:0]             fuse_ok;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_slot
            assign slot[g] = iq_out[g*`FDFE_INS_W +: `FDFE_INS_W];
        end
        for (g = 0; g < 3; g = g + 1) begin : g_fuse
            fdfe_fuse u_fuse (
                .first   (slot[g]),
                .second  (slot[g+1]),
                .fusable (fuse_ok[g])
            );
        end
    endgenerate

    // decoder group: slots 1-3 simple only, slot 0 any
    reg [`FDFE_UOP_W-1:0] dec_uop [0:3];
    reg [2:0]             n_uops;
    reg                   need_ucode;
    reg [2:0]             ucode_len;
    reg [3:0]             skip;
    reg [2:0]             cnt;
    integer               i;
    integer               j;
    always @* begin
        n_uops     = 3'd0;
        need_ucode = 1'b0;
        ucode_len  = 3'd0;
        skip       = 4'h0;
        cnt        = 3'd0;
        for (i = 0; i < 4; i = i + 1)
            dec_uop[i] = {`FDFE_UOP_W{1'b0}};
        // micro-ops packed in order; slots past a full group are dropped
        for (i = 0; i < 4; i = i + 1) begin
            cnt = slot[i][`FDFE_F_CNT_HI:`FDFE_F_CNT_LO];
            if (iq_out[4*`FDFE_INS_W+i] && !skip[i] && n_uops != 3'd4) begin
                if (i < 3 && fuse_ok[i] && (long_mode || 1'b1)
                    && iq_out[4*`FDFE_INS_W+i+1]) begin
                    // one micro-op for the pair, 64-bit too
                    dec_uop[n_uops[1:0]] = {slot[i+1][15:8],
                                            `FDFE_CLS_FUSED};
                    n_uops    = n_uops + 3'd1;
                    skip[i+1] = 1'b1;
                end else if (slot[i][`FDFE_F_CLS_HI:`FDFE_F_CLS_LO]
                             == `FDFE_CLS_UCODE || (i == 0 && cnt > 3'd3)) begin
                    // long sequence: sequencer takes over in slot 0; in slots 1-3 the rest of the line is dropped
                    if (i == 0) begin
                        need_ucode = 1'b1;
                        ucode_len  = cnt;
                    end
                    skip = skip | (4'hf << i);
                end else if (cnt != 3'd0 && i != 0) begin
                    skip = skip | (4'hf << i);
                end else begin
                    // slot 0 may expand to up to four micro-ops
                    for (j = 0; j < 4; j = j + 1)
                        if (j <= cnt)
                            dec_uop[n_uops[1:0] + j[1:0]] =
                                slot[i][`FDFE_UOP_W-1:0];
                    n_uops = n_uops + cnt + 3'd1;
                end
            end
        end
    end

    // decoded-op queue with loop buffer
    reg [`FDFE_UOP_W-1:0] decoded_op_queue [0:`FDFE_IDQ_DEPTH-1];
    reg [`FDFE_IDQ_AW:0]  idq_cnt;
    reg [`FDFE_IDQ_AW-1:0] idq_wr;
    reg [`FDFE_IDQ_AW-1:0] idq_rd;
    reg [1:0]             state;
    reg [2:0]             uc_left;
    reg [`FDFE_IDQ_AW-1:0] loop_start;
    reg [`FDFE_IDQ_AW-1:0] loop_end;
    wire                  idq_pop;
    wire [`FDFE_IDQ_AW:0] free_slots;
    reg                   do_dec;
    reg [2:0]             wr_n;
    localparam [`FDFE_IDQ_AW:0] IDQ_FULL = `FDFE_IDQ_DEPTH;

    assign free_slots = IDQ_FULL - idq_cnt;
    assign uop_valid  = (idq_cnt != 0) | (state == ST_LOOP);
    assign uop_data   = decoded_op_queue[idq_rd];
    assign idq_pop    = uop_valid & uop_ready;

    // decode fires only with room for every micro-op made
    always @* begin
        do_dec = 1'b0;
        iq_pop = 1'b0;
        wr_n   = 3'd0;
        if (state == ST_UCODE) begin
            wr_n = (uc_left > 3'd3) ? 3'd4 : uc_left + 3'd1;
            if (free_slots < {2'b00, wr_n})
                wr_n = 3'd0;
        end else if (state == ST_RUN && iq_out_valid && my_turn) begin
            if (free_slots >= {2'b00, n_uops}) begin
                do_dec = 1'b1;
                iq_pop = 1'b1;
                wr_n   = n_uops;
            end
        end
    end

    // queue storage, sequencer and loop detection
    integer k;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idq_cnt    <= 0;
            idq_wr     <= 0;
            idq_rd     <= 0;
            state      <= ST_RUN;
            uc_left    <= 3'd0;
            lsd_active <= 1'b0;
            loop_start <= 0;
            loop_end   <= 0;
            flush_done <= 1'b0;
            for (k = 0; k < `FDFE_IDQ_DEPTH; k = k + 1)
                decoded_op_queue[k] <= {`FDFE_UOP_W{1'b0}};
        end else if (mispredict) begin
            // drop wrong path now; no wait on reclamation
            idq_cnt    <= 0;
            idq_wr     <= 0;
            idq_rd     <= 0;
            state      <= ST_RUN;
            lsd_active <= 1'b0;
            flush_done <= 1'b1;
        end else begin
            flush_done <= 1'b0;
            if (state == ST_LOOP) begin
                // replay from the loop buffer, no decode; fetch still fills the instruction queue
                if (idq_pop)
                    idq_rd <= (idq_rd == loop_end) ? loop_start
                                                   : idq_rd + 1'b1;
            end else begin
                for (k = 0; k < 4; k = k + 1) begin
                    if (k < wr_n)
                        decoded_op_queue[idq_wr + k[`FDFE_IDQ_AW-1:0]] <=
                            (state == ST_UCODE) ?
                            {`FDFE_CLS_UCODE, 5'd0, uc_left} :
                            dec_uop[k];
                end
                idq_wr  <= idq_wr + {1'b0, wr_n};
                idq_cnt <= idq_cnt + {2'b00, wr_n}
                           - {{`FDFE_IDQ_AW{1'b0}}, idq_pop};
                if (idq_pop)
                    idq_rd <= idq_rd + 1'b1;
                if (state == ST_UCODE && wr_n != 3'd0) begin
                    if (uc_left < 3'd4)
                        state <= ST_RUN;
                    else
                        uc_left <= uc_left - 3'd4;
                end else if (do_dec && need_ucode) begin
                    state   <= ST_UCODE;
                    uc_left <= ucode_len;
                end
                // backward-taken loop end held whole: lock replay
                if (do_dec && slot[0][7:0] == `FDFE_CLS_LOOPEND
                    && idq_cnt + {2'b00, wr_n} <= `FDFE_LSD_MAX) begin
                    // loop body runs through the loop end just written
                    state      <= ST_LOOP;
                    lsd_active <= 1'b1;
                    loop_start <= idq_pop ? idq_rd + 1'b1 : idq_rd;
                    loop_end   <= idq_wr + {1'b0, wr_n} - 1'b1;
                end
            end
        end
    end

    // return stack buffer, renamed by pointer checkpoint
    reg [`FDFE_ADDR_W-1:0] rsb [0:`FDFE_RSB_DEPTH-1];
    reg [2:0]              rsb_top;
    reg [2:0]              rsb_ckpt;
    wire                   is_call;
    wire                   is_ret;
    assign is_call = do_dec && slot[0][7:0] == `FDFE_CLS_CALL;
    assign is_ret  = do_dec && slot[0][7:0] == `FDFE_CLS_RET;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rsb_top     <= 3'd0;
            rsb_ckpt    <= 3'd0;
            ret_predict <= {`FDFE_ADDR_W{1'b0}};
            for (k = 0; k < `FDFE_RSB_DEPTH; k = k + 1)
                rsb[k] <= {`FDFE_ADDR_W{1'b0}};
        end else if (mispredict) begin
            rsb_top <= rsb_ckpt;
        end else begin
            if (is_call) begin
                rsb[rsb_top + 3'd1] <= call_ret_addr;
                rsb_top  <= rsb_top + 3'd1;
            end else if (is_ret) begin
                ret_predict <= rsb[rsb_top];
                rsb_top     <= rsb_top - 3'd1;
            end
            if (!iq_out_valid)
                rsb_ckpt <= rsb_top; // settled point to rename back to
        end
    end
endmodule // fdfe_front_end

// File: fdfe_front_end_checker.sv
// fdfe_front_end_checker.sv: port assertions for the front end
// assumes a bind onto fdfe_front_end, one clock, async reset
`timescale 1ns/10ps
`include "fdfe_consts.vh"
module fdfe_chk (
    // clock and reset
    input wire                   mclk,
    input wire                   sys_rst,
    // fetch side
    input wire                   fetch_valid,
    input wire                   fetch_ready,
    input wire [3:0]             ld_mask,
    input wire                   mispredict,
    // micro-op side and status
    input wire                   uop_valid,
    input wire                   uop_ready,
    input wire [`FDFE_UOP_W-1:0] uop_data,
    input wire                   lsd_active,
    input wire                   flush_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // a line taken, and an offer held back by the rename side
    sequence s_take;
        fetch_valid && fetch_ready && ld_mask != 4'h0 && !mispredict;
    endsequence
    sequence s_held;
        uop_valid && !uop_ready && !mispredict;
    endsequence
    sequence s_flush;
        mispredict;
    endsequence
    wake_quiet_a:
        assert property ($fell(sys_rst) |-> fetch_ready ##0 (!uop_valid)[*2])
        else $error("front end not idle after reset");
    take_answer_a:
        assert property (s_take |-> ##[1:64] (uop_valid || mispredict))
        else $error("taken line produced no micro-op");
    uop_hold_a:
        assert property (s_held |=> uop_valid && $stable(uop_data))
        else $error("micro-op changed while stalled");
    flush_pulse_a:
        assert property (s_flush |=> flush_done)
        else $error("flush done missing after misprediction");
    flush_once_a:
        assert property (flush_done && !mispredict |=> !flush_done)
        else $error("flush done longer than one cycle");
    flush_empty_a:
        assert property (s_flush |=> !uop_valid)
        else $error("stale micro-op offered after flush");
    loop_exit_a:
        assert property (s_flush |-> ##[1:2] !lsd_active)
        else $error("loop replay survived a misprediction");
    loop_lock_a:
        assert property (lsd_active && !mispredict |=> lsd_active)
        else $error("loop replay ended without misprediction");
endmodule // fdfe_chk

bind fdfe_front_end fdfe_chk u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready), .ld_mask(ld_mask), .mispredict(mispredict),
    .uop_valid(uop_valid), .uop_ready(uop_ready), .uop_data(uop_data),
    .lsd_active(lsd_active), .flush_done(flush_done)
);

// File: fdfe_rename_model.sv
// fdfe_rename_model.sv: rename stage taking micro-ops, paced by the bench
// assumes valid/ready; ready changes only just after a clock edge
`timescale 1ns/10ps
`include "fdfe_consts.vh"
module fdfe_rename_model (
    // clock and reset
    input  wire                   mclk,
    input  wire                   sys_rst,
    // pace: 0 prompt, 1 slow, 2 stalled
    input  wire [1:0]             pace,
    // micro-op stream
    input  wire                   uop_valid,
    output reg                    uop_ready,
    input  wire [`FDFE_UOP_W-1:0] uop_data,
    // tally of what was taken
    output int                    taken_cnt,
    output reg  [`FDFE_UOP_W-1:0] last_uop
);
    reg [7:0] lf;
    // pacing and take bookkeeping; stalls exercise decode hold-off
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lf <= 8'h5e;
            uop_ready <= 1'b0;
            taken_cnt <= 0;
            last_uop <= 16'h0000;
        end else begin
            lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
            uop_ready <= (pace == 2'h0) | ((pace == 2'h1) & lf[0]);
            if (uop_valid && uop_ready) begin
                taken_cnt <= taken_cnt + 1;
                last_uop <= uop_data;
            end
        end
    end
endmodule // fdfe_rename_model

// File: testbench.sv
// testbench.sv: self-checking bench for the fetch and decode front end
// assumes the rename model as far side; the bench plays the cache
`timescale 1ns/10ps
`include "fdfe_consts.vh"
module testbench;
    reg         mclk, sys_rst, smt_enable, long_mode, fetch_valid;
    reg         fetch_thread, mispredict, ok;
    reg [127:0] fetch_bytes;
    reg [95:0]  ld_ins;
    reg [3:0]   ld_mask, m;
    reg [31:0]  call_ret_addr, addr;
    reg [7:0]   seed, cls;
    reg [1:0]   pace;
    wire        fetch_ready, uop_valid, uop_ready, lsd_active, flush_done;
    wire [15:0] uop_data, last_uop;
    wire [31:0] ret_predict;
    int         taken_cnt, error_cnt, checks, n, base, i;

    fdfe_front_end u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .smt_enable(smt_enable), .long_mode(long_mode),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .fetch_bytes(fetch_bytes), .ld_ins(ld_ins), .ld_mask(ld_mask),
        .fetch_thread(fetch_thread), .mispredict(mispredict),
        .call_ret_addr(call_ret_addr), .uop_valid(uop_valid),
        .uop_ready(uop_ready), .uop_data(uop_data), .lsd_active(lsd_active),
        .ret_predict(ret_predict), .flush_done(flush_done));
    fdfe_rename_model u_far (.mclk(mclk), .sys_rst(sys_rst), .pace(pace),
        .uop_valid(uop_valid), .uop_ready(uop_ready), .uop_data(uop_data),
        .taken_cnt(taken_cnt), .last_uop(last_uop));

    // clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // stimulus helpers and expectation functions
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [23:0] mk(input [7:0] c, input [2:0] cnt, input [3:0] cc,
                       input [1:0] form);
        mk = {7'h00, form, cc, cnt, c};
    endfunction
    function fuse_exp(input [7:0] c, input [3:0] cc);
        fuse_exp = (c == `FDFE_CLS_TEST) || (cc inside {`FDFE_CC_A,
            `FDFE_CC_AE, `FDFE_CC_E, `FDFE_CC_BE, `FDFE_CC_B, `FDFE_CC_NE,
            `FDFE_CC_L, `FDFE_CC_GE, `FDFE_CC_LE, `FDFE_CC_G});
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task timed_out;
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: wait ran out, seen %h expected %h",
                 $time, 1'b0, 1'b1);
        close_out;
    endtask
    // offer a line at a rising edge; held until taken
    task offer(input [95:0] ins, input [3:0] mask);
        seed = lfsr(seed);
        fetch_valid <= 1'b1;
        ld_ins <= ins;
        ld_mask <= mask;
        fetch_bytes <= {16{seed}};
    endtask
    task wait_take(input int bound, output reg got);
        got = 1'b0;
        for (int k = 0; k < bound && !got; k++) begin
            @(negedge mclk);
            got = (fetch_ready === 1'b1);
            @(posedge mclk);
        end
    endtask
    task send(input [95:0] ins, input [3:0] mask);
        reg got;
        offer(ins, mask);
        wait_take(200, got);
        if (!got) timed_out();
    endtask
    task idle;
        fetch_valid <= 1'b0;
        ld_mask <= 4'h0;
        @(posedge mclk);
    endtask
    // wait until no micro-op has been taken for 16 cycles
    task drain;
        int q, last;
        q = 0;
        for (int k = 0; k < 3000 && q < 16; k++) begin
            last = taken_cnt;
            @(negedge mclk);
            q = (taken_cnt == last) ? q + 1 : 0;
        end
        if (q < 16) timed_out();
        @(posedge mclk);
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        {smt_enable, long_mode, fetch_valid, fetch_thread, mispredict} = 5'h0;
        fetch_bytes = 128'h0;
        ld_ins = 96'h0;
        ld_mask = 4'h0;
        call_ret_addr = 32'h0000_0000;
        pace = 2'h0;
        seed = 8'h5e;
        error_cnt = 0;
        checks = 0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // pair fusion over both first ops, every condition, random forms
        for (i = 0; i < 32; i++) begin
            cls = i[4] ? `FDFE_CLS_TEST : `FDFE_CLS_CMP;
            long_mode <= seed[2];
            base = taken_cnt;
            send({48'h0, mk(`FDFE_CLS_JCC, 3'h0, i[3:0], 2'h0),
                  mk(cls, 3'h0, 4'h0, seed[1:0])}, 4'h3);
            idle;
            drain;
            n = fuse_exp(cls, i[3:0]) ? 1 : 2;
            check(taken_cnt - base, n);
            if (n == 1)
                check(last_uop[7:0], `FDFE_CLS_FUSED);
        end
        $display("test fusion done");
        // random simple lines, slow rename side, thread alternation on, all lines from thread 1
        pace <= 2'h1;
        smt_enable <= 1'b1;
        fetch_thread <= 1'b1;
        base = taken_cnt;
        n = 0;
        for (i = 0; i < 24; i++) begin
            m = (seed[3:0] == 4'h0) ? 4'hf : seed[3:0];
            n = n + $countones(m);
            send({4{mk(`FDFE_CLS_OTHER, 3'h0, seed[7:4], seed[5:4])}}, m);
        end
        idle;
        drain;
        check(taken_cnt - base, n);
        $display("test random lines done");
        // four micro-ops from a decoder, five from the sequencer
        pace <= 2'h0;
        smt_enable <= 1'b0;
        for (i = 0; i < 2; i++) begin
            base = taken_cnt;
            cls = i ? `FDFE_CLS_UCODE : `FDFE_CLS_OTHER;
            send({72'h0, mk(cls, i ? 3'h4 : 3'h3, 4'h0, 2'h0)}, 4'h1);
            idle;
            drain;
            check(taken_cnt - base, i ? 5 : 4);
        end
        $display("test long instructions done");
        // rename side stalls until lines are refused, then all drain
        pace <= 2'h2;
        base = taken_cnt;
        ok = 1'b1;
        n = 0;
        while (ok && n < 40) begin
            offer({4{mk(`FDFE_CLS_OTHER, 3'h0, 4'h0, 2'h0)}}, 4'hf);
            wait_take(8, ok);
            n = n + ok;
        end
        check(ok, 1'b0);
        check(n >= 16, 1'b1);
        pace <= 2'h0;
        wait_take(200, ok);
        if (!ok) timed_out();
        idle;
        drain;
        check(taken_cnt - base, 4 * (n + 1));
        $display("test stall done");
        // a call then a return predicts the pushed address
        addr = {4{seed}};
        call_ret_addr <= addr;
        send({72'h0, mk(`FDFE_CLS_CALL, 3'h0, 4'h0, 2'h0)}, 4'h1);
        send({72'h0, mk(`FDFE_CLS_RET, 3'h0, 4'h0, 2'h0)}, 4'h1);
        idle;
        drain;
        check(ret_predict, addr);
        $display("test return stack done");
        // loop end locks replay; a misprediction ends it and flushes
        send({72'h0, mk(`FDFE_CLS_LOOPEND, 3'h0, 4'h0, 2'h0)}, 4'h1);
        idle;
        for (i = 0; i < 50 && lsd_active !== 1'b1; i++) @(negedge mclk);
        check(lsd_active, 1'b1);
        @(posedge mclk);
        mispredict <= 1'b1;
        @(posedge mclk);
        mispredict <= 1'b0;
        @(negedge mclk);
        check(flush_done, 1'b1);
        @(negedge mclk);
        check(lsd_active, 1'b0);
        @(posedge mclk);
        base = taken_cnt;
        send({4{mk(`FDFE_CLS_OTHER, 3'h0, 4'h0, 2'h1)}}, 4'hf);
        idle;
        drain;
        check(taken_cnt - base, 4);
        $display("test misprediction done");
        close_out;
    end
endmodule // testbench
